// >>> logic/uph_pkg.sv
// Shared constants and state types for the ULPI pin handshake ends
package uph_pkg;

	// ==========================================================
	// Bus shape
	// Data bus width, with bit 7 the most significant
	localparam int DATA_W = 8;
	localparam int DATA_MSB = 7;
	localparam int DATA_LSB = 0;
	// Value carried on an idle bus and in a stop cycle
	localparam logic [7:0] BUS_IDLE = 8'h00;

	// ==========================================================
	// Timing
	// Own clock period
	localparam int CLK_PERIOD_NS = 100;
	// Interface clock period made by the transceiver end
	localparam int IF_PERIOD_NS = 800;
	// Own clock cycles in each half of the interface clock
	localparam int HALF_CYC = IF_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam logic [2:0] DIV_LAST = 3'(HALF_CYC - 1);
	// Cycles without a reference edge before the divider stops
	localparam logic [3:0] REF_LOST_CYC = 4'h8;

	// ==========================================================
	// Transceiver end state
	typedef enum logic [1:0] {P_IDLE, P_UP, P_SEND, P_DOWN} uph_phy_e;
	typedef struct packed {
		uph_phy_e st;
		logic [2:0] div;
		logic clk_o;
		logic [3:0] ref_cnt;
		logic ref_p;
		logic dir_r;
		logic nxt_r;
		logic [7:0] data_r;
		logic last_r;
		logic busy;
		logic have_pend;
		logic [7:0] pend;
		logic [7:0] rx_data_r;
		logic rx_valid_r;
		logic rx_last_r;
		logic vbus_r;
	} uph_phy_s;
	localparam uph_phy_s PHY_RST = '0;

	// ==========================================================
	// Link end state
	typedef enum logic [1:0] {L_IDLE, L_SEND, L_STOP} uph_link_e;
	typedef struct packed {
		uph_link_e st;
		logic clk_p;
		logic dir_p;
		logic sdir;
		logic snxt;
		logic [7:0] sdata;
		logic [7:0] byte_r;
		logic last_r;
		logic stp_r;
		logic [7:0] rx_data_r;
		logic rx_valid_r;
		logic rx_end_r;
		logic rstl_r;
	} uph_link_s;
	localparam uph_link_s LINK_RST = '0;

endpackage

// >>> logic/uph_if.sv
// Pin bundle joining the transceiver end and the link end
`timescale 1ns/1ps
interface uph_if;
	import uph_pkg::*;

	// ==========================================================
	// Driven pieces and resolved wires
	// Clock made by the transceiver, with its enable
	logic interface_clock_out;
	logic interface_clock_oe;
	logic if_clk;
	// Direction and throttle from the transceiver
	logic phy_dir;
	logic phy_dir_oe;
	logic dir;
	logic phy_nxt;
	logic phy_nxt_oe;
	logic nxt;
	// Shared data bus, one driver piece per end
	logic [uph_pkg::DATA_W-1:0] phy_data;
	logic phy_data_oe;
	logic [uph_pkg::DATA_W-1:0] link_data;
	logic link_data_oe;
	logic [uph_pkg::DATA_W-1:0] data;
	// Link-driven stop and transceiver reset
	logic stp;
	logic chip_reset_low;

	// Undriven pins read low, as with a weak pull-down
	assign if_clk = interface_clock_oe & interface_clock_out;
	assign dir = phy_dir_oe & phy_dir;
	assign nxt = phy_nxt_oe & phy_nxt;
	// [R10] Bit order kept
	// Lane i of each piece lands on line i, bit 7 most significant
	assign data = phy_data_oe ? phy_data : (link_data_oe ? link_data : BUS_IDLE);

	modport phy_mp (
		output interface_clock_out,
		output interface_clock_oe,
		output phy_dir,
		output phy_dir_oe,
		output phy_nxt,
		output phy_nxt_oe,
		output phy_data,
		output phy_data_oe,
		input data,
		input stp,
		input chip_reset_low
	);
	modport link_mp (
		input if_clk,
		input dir,
		input nxt,
		input data,
		output link_data,
		output link_data_oe,
		output stp,
		output chip_reset_low
	);
endinterface

// >>> logic/uph_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module uph_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	import uph_pkg::*;

	// Both stages kept together; only the second is read outside
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} uph_sync_s;
	uph_sync_s r;
	uph_sync_s n;

	// ==========================================================
	// Next stage values
	always_comb
	begin
		n.s1 = d;
		n.s2 = r.s1;
	end

	// Stage registers
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			r <= '0;
		else
			r <= n;
	end

	assign q = r.s2;
endmodule

// >>> logic/uph_phy_end.sv
// Transceiver end of the ULPI pin handshake
//
// Notes on behaviour
// [R1] Both ends launch on interface clock rise
// [R2] NXT high means current byte taken
// [R3] Link shows next byte after NXT
// [R4] Transceiver raises DIR to send, owns bus
// [R5] Nothing to send: DIR low, watch bus
// [R6] Link ends stream with one-cycle STP
// [R7] Byte before STP is the last one
// [R8] Reset low: suspended, all pins released
// [R9] Reset high: normal interface operation
// [R10] Data line 7 is MSB, 0 LSB
// [R11] Interface clock derived from reference clock; code divides own clock, reference presence only enables the divider
// [R12] VBUS pin both sensed and pulsed
// [R13] Speaker switches closed while reset low
// [R14] No driver in DIR change cycle
`timescale 1ns/1ps
module uph_phy_end (
	input wire logic clk,
	input wire logic rst,
	// Pin side towards the link
	uph_if.phy_mp ulpi,
	// Reference clock pin, free running
	input wire logic reference_clock_in,
	// Cable VBUS pin pieces
	input wire logic vbus_in,
	output logic vbus_out,
	output logic vbus_oe,
	// Speaker switch control
	output logic speaker_switch_closed,
	// User request for a VBUS pulse
	input wire logic vbus_pulse_req,
	// Sensed VBUS level
	output logic vbus_seen,
	// Bytes to send towards the link
	input wire logic ptx_valid,
	input wire logic [uph_pkg::DATA_W-1:0] ptx_data,
	input wire logic ptx_last,
	output logic ptx_ready,
	// Bytes received from the link
	input wire logic rx_ready,
	output logic [uph_pkg::DATA_W-1:0] rx_data,
	output logic rx_valid,
	output logic rx_last
);
	import uph_pkg::*;

	// ==========================================================
	// Declarations
	// Registered state and its next value
	uph_phy_s r;
	uph_phy_s n;
	// Synchronised pins
	logic [11:0] pins_s;
	logic rstl_s;
	logic ref_s;
	logic vbus_s;
	logic stp_s;
	logic [7:0] data_s;
	// Reference still toggling
	logic ref_alive;
	// Step where the interface clock rises
	logic rise;

	// ==========================================================
	// Pin synchronisers
	// All pins share one chain so they stay aligned
	uph_sync #(
		.W(12)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.d({ulpi.chip_reset_low, reference_clock_in, vbus_in, ulpi.stp, ulpi.data}),
		.q(pins_s)
	);

	// Split the chain output
	assign rstl_s = pins_s[11];
	assign ref_s = pins_s[10];
	assign vbus_s = pins_s[9];
	assign stp_s = pins_s[8];
	assign data_s = pins_s[7:0];

	// [R11] Reference clock watch
	// A stopped reference also stops the interface clock
	assign ref_alive = (r.ref_cnt != REF_LOST_CYC);

	// ==========================================================
	// Next state
	// Handshake decisions are made on the rise step, using pins
	// sampled just before it, so the far end had a whole period
	always_comb
	begin
		n = r;
		rise = 1'b0;
		ptx_ready = 1'b0;
		n.rx_valid_r = 1'b0;
		n.vbus_r = vbus_s;
		n.ref_p = ref_s;
		// Edge on the reference restarts the loss counter
		if (ref_s != r.ref_p)
			n.ref_cnt = 4'h0;
		else if (ref_alive)
			n.ref_cnt = r.ref_cnt + 4'h1;
		// [R8] Suspend under reset pin
		if (!rstl_s)
		begin
			// Held in idle; clock and handshake stopped
			n = PHY_RST;
		end
		// [R9] Normal operation
		else if (ref_alive)
		begin
			// [R11] Divider from own clock
			n.div = r.div + 3'h1;
			if (r.div == DIV_LAST)
			begin
				// Half period done, flip the clock
				n.div = 3'h0;
				n.clk_o = !r.clk_o;
				rise = !r.clk_o;
			end
		end
		// [R1] Launch on rise
		if (rise)
		begin
			case (r.st)
				P_IDLE:
				begin
					// [R6] Stop from the link
					if (stp_s)
					begin
						// [R7] Pending byte is last
						if (r.have_pend)
						begin
							n.rx_data_r = r.pend;
							n.rx_valid_r = 1'b1;
							n.rx_last_r = 1'b1;
						end
						n.busy = 1'b0;
						n.have_pend = 1'b0;
					end
					// [R2] Byte taken under NXT
					else if (r.busy && r.nxt_r)
					begin
						// Older byte released once a newer one is in
						if (r.have_pend)
						begin
							n.rx_data_r = r.pend;
							n.rx_valid_r = 1'b1;
							n.rx_last_r = 1'b0;
						end
						n.pend = data_s;
						n.have_pend = 1'b1;
					end
					// [R5] Watch bus for commands
					else if (!r.busy && data_s != BUS_IDLE)
					begin
						// Non-idle byte opens a transfer
						n.busy = 1'b1;
					end
					// [R2] Throttle by user
					n.nxt_r = n.busy & rx_ready;
					// [R4] Take the bus
					if (!n.busy && ptx_valid && data_s == BUS_IDLE)
					begin
						// Turnaround period, data not yet driven
						n.st = P_UP;
						n.dir_r = 1'b1;
						n.nxt_r = 1'b0;
					end
				end
				P_UP, P_SEND:
				begin
					// One byte each period until the last
					if (ptx_valid && !(r.st == P_SEND && r.last_r))
					begin
						ptx_ready = 1'b1;
						n.data_r = ptx_data;
						n.last_r = ptx_last;
						n.nxt_r = 1'b1;
						n.st = P_SEND;
					end
					// [R5] Hand bus back
					else
					begin
						n.st = P_DOWN;
						n.dir_r = 1'b0;
						n.nxt_r = 1'b0;
						n.data_r = BUS_IDLE;
					end
				end
				P_DOWN:
				begin
					// [R14] Turnaround after DIR falls
					// Link may drive only from the next period
					n.st = P_IDLE;
				end
				default:
				begin
					n.st = P_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			r <= PHY_RST;
		else
			r <= n;
	end

	// ==========================================================
	// Pin drivers
	// [R8] Release every pin
	// Enables follow the synchronised reset, so release lags two cycles
	assign ulpi.interface_clock_out = r.clk_o;
	assign ulpi.interface_clock_oe = rstl_s;
	assign ulpi.phy_dir = r.dir_r;
	assign ulpi.phy_dir_oe = rstl_s;
	assign ulpi.phy_nxt = r.nxt_r;
	assign ulpi.phy_nxt_oe = rstl_s;
	assign ulpi.phy_data = r.data_r;
	// [R14] No drive in turnaround
	assign ulpi.phy_data_oe = rstl_s & (r.st == P_SEND);

	// [R13] Switches closed in reset
	assign speaker_switch_closed = !rstl_s;

	// [R12] VBUS sensed and pulsed
	// Pulse drive is a plain high level while requested
	assign vbus_out = 1'b1;
	assign vbus_oe = vbus_pulse_req & rstl_s;
	assign vbus_seen = r.vbus_r;

	// ==========================================================
	// User outputs
	assign rx_data = r.rx_data_r;
	assign rx_valid = r.rx_valid_r;
	assign rx_last = r.rx_last_r;
endmodule

// >>> logic/uph_link_end.sv
// Link end of the ULPI pin handshake
`timescale 1ns/1ps
module uph_link_end (
	input wire logic clk,
	input wire logic rst,
	// Pin side towards the transceiver
	uph_if.link_mp ulpi,
	// Holds the transceiver in reset while high
	input wire logic phy_reset_req,
	// Bytes to send; first byte must be non-idle
	input wire logic tx_valid,
	input wire logic [uph_pkg::DATA_W-1:0] tx_data,
	input wire logic tx_last,
	output logic tx_ready,
	// Bytes received from the transceiver
	output logic [uph_pkg::DATA_W-1:0] rx_data,
	output logic rx_valid,
	output logic rx_end
);
	import uph_pkg::*;

	// ==========================================================
	// Declarations
	// Registered state and its next value
	uph_link_s r;
	uph_link_s n;
	// Synchronised pins
	logic [10:0] pins_s;
	logic clk_s;
	logic dir_s;
	// Interface clock edges seen on own clock
	logic rise;
	logic fall;
	// Bus free in the period now starting
	logic free;

	// ==========================================================
	// Pin synchronisers
	// Clock and data share a chain so edges and data stay aligned
	uph_sync #(
		.W(11)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.d({ulpi.if_clk, ulpi.dir, ulpi.nxt, ulpi.data}),
		.q(pins_s)
	);

	assign clk_s = pins_s[10];
	assign dir_s = pins_s[9];
	assign rise = clk_s & !r.clk_p;
	assign fall = !clk_s & r.clk_p;
	assign free = !r.sdir & !dir_s;

	// ==========================================================
	// Next state
	// Pins are sampled at mid period and acted on at the rise
	always_comb
	begin
		n = r;
		tx_ready = 1'b0;
		n.clk_p = clk_s;
		n.rx_valid_r = 1'b0;
		n.rx_end_r = 1'b0;
		n.rstl_r = !phy_reset_req;
		// Mid-period sample of transceiver outputs
		if (fall)
		begin
			n.sdir = pins_s[9];
			n.snxt = pins_s[8];
			n.sdata = pins_s[7:0];
		end
		// [R1] Launch on rise
		if (rise)
		begin
			n.dir_p = r.sdir;
			// Data from the transceiver is marked by NXT
			if (r.sdir && r.snxt)
			begin
				n.rx_data_r = r.sdata;
				n.rx_valid_r = 1'b1;
			end
			// Direction fell: receive stream over
			if (r.dir_p && !r.sdir)
				n.rx_end_r = 1'b1;
			case (r.st)
				L_IDLE:
				begin
					// First byte goes out only on a free bus
					if (free)
					begin
						tx_ready = 1'b1;
						if (tx_valid)
						begin
							n.byte_r = tx_data;
							n.last_r = tx_last;
							n.st = L_SEND;
						end
					end
				end
				L_SEND:
				begin
					// Bus taken away: abandon the stream
					if (!free)
					begin
						n.byte_r = BUS_IDLE;
						n.st = L_IDLE;
					end
					// [R3] Next byte after NXT
					else if (r.snxt)
					begin
						tx_ready = !r.last_r;
						if (tx_valid && !r.last_r)
						begin
							n.byte_r = tx_data;
							n.last_r = tx_last;
						end
						// [R6] One-cycle stop
						// [R7] Previous byte was last
						// An empty source also ends the stream
						else
						begin
							n.stp_r = 1'b1;
							n.byte_r = BUS_IDLE;
							n.st = L_STOP;
						end
					end
				end
				L_STOP:
				begin
					n.stp_r = 1'b0;
					n.st = L_IDLE;
				end
				default:
				begin
					n.st = L_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			r <= LINK_RST;
		else
			r <= n;
	end

	// ==========================================================
	// Pin drivers
	// [R14] Off in turnaround
	// Released the moment DIR is seen high, back only a period after it falls
	assign ulpi.link_data_oe = !dir_s & !r.dir_p;
	assign ulpi.link_data = r.byte_r;
	assign ulpi.stp = r.stp_r;
	assign ulpi.chip_reset_low = r.rstl_r;

	// User outputs
	assign rx_data = r.rx_data_r;
	assign rx_valid = r.rx_valid_r;
	assign rx_end = r.rx_end_r;
endmodule

// >>> tb/uph_asserts.sv
// Pin-level checks between the transceiver end and the link end
`timescale 1ns/1ps
module uph_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire logic if_clk,
	input wire logic interface_clock_oe,
	input wire logic dir,
	input wire logic phy_dir_oe,
	input wire logic nxt,
	input wire logic phy_nxt_oe,
	input wire logic [uph_pkg::DATA_W-1:0] data,
	input wire logic phy_data_oe,
	input wire logic link_data_oe,
	input wire logic stp,
	input wire logic chip_reset_low
);
	import uph_pkg::*;
	// ==========================================
	// Clocking
	// One domain, so one default for all checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// ==========================================
	// Checks
	a_no_bus_fight: assert property (!(phy_data_oe && link_data_oe))
		else $error("both ends drive the data bus");
	a_rise_quiet: assert property ($rose(dir) |-> !phy_data_oe [*4])
		else $error("data driven in turnaround up");
	a_fall_quiet: assert property ($fell(dir) |->
		(!phy_data_oe && !link_data_oe) [*4])
		else $error("data driven in turnaround down");
	a_reset_pins_off: assert property (!chip_reset_low [*3] |->
		!(interface_clock_oe || phy_dir_oe || phy_nxt_oe || phy_data_oe))
		else $error("pins driven while asleep");
	a_wake_clock: assert property (chip_reset_low [*8] |-> interface_clock_oe)
		else $error("no interface clock after wake");
	// Sleep cuts a period short, so it disables this one
	a_clk_period: assert property (disable iff (rst || !chip_reset_low)
		$rose(if_clk) |-> if_clk [*4] ##1 !if_clk [*4])
		else $error("interface clock period wrong");
	// Pins move at the same own-clock edge that raises the interface clock
	a_launch_on_rise: assert property (phy_dir_oe && $past(phy_dir_oe)
		&& $changed({dir, nxt}) |-> $rose(if_clk))
		else $error("dir or nxt moved off the clock rise");
	a_stp_one_period: assert property ($rose(stp) |-> stp [*8] ##1 !stp)
		else $error("stop not one period long");
	a_stp_idle_bus: assert property (stp |-> data == BUS_IDLE)
		else $error("data carried in stop period");
	a_idle_phy_quiet: assert property (!dir && !$past(dir) |-> !phy_data_oe)
		else $error("transceiver drives bus with dir low");
	a_phy_owns_dir: assert property (phy_data_oe |-> dir && nxt)
		else $error("transceiver data without dir and nxt");
	// ==========================================
	// Coverage of the main scenarios
	c_link_stream: cover property ($rose(stp));
	c_phy_stream: cover property ($fell(dir));
	c_sleep: cover property ($fell(chip_reset_low));
endmodule

// >>> tb/tb_top.sv
// Self-checking bench joining both ends of the pin handshake
`timescale 1ns/1ps
module tb_top;
	import uph_pkg::*;
	// ==========================================
	// Bench signals
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ref_clk = 1'b0;
	logic vbus_in = 1'b0;
	logic vbus_pulse_req = 1'b0;
	logic ptx_valid = 1'b0;
	logic [7:0] ptx_data = 8'h00;
	logic ptx_last = 1'b0;
	logic rx_ready = 1'b1;
	logic phy_reset_req = 1'b0;
	logic tx_valid = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic tx_last = 1'b0;
	logic ptx_ready, vbus_out, vbus_oe, speaker_switch_closed, vbus_seen;
	logic p_rx_valid, p_rx_last, tx_ready, l_rx_valid, l_rx_end;
	logic [7:0] p_rx_data, l_rx_data;
	logic [8:0] prx[$]; // Transceiver deliveries, last flag on top
	logic [7:0] lrx[$];
	logic [7:0] wq[$]; // Bytes seen on the wire with nxt high
	int n_errors = 0;
	int n_compared = 0;
	int n_end = 0;
	int cyc = 0;
	// Stream table: direction, length, first byte
	typedef struct packed {logic up; logic [3:0] n; logic [7:0] b0;} uph_row_s;
	uph_row_s rows [6] = '{'{1'b0, 4'd1, 8'h81}, '{1'b1, 4'd1, 8'h00},
		'{1'b0, 4'd4, 8'h10}, '{1'b1, 4'd3, 8'hfd}, '{1'b0, 4'd3, 8'hfd},
		'{1'b1, 4'd5, 8'h80}};
	// ==========================================
	// Clocks and the two ends
	always #50 clk = ~clk;
	// Reference supplied, unrelated in phase to the own clock
	always #19.23 ref_clk = ~ref_clk;
	uph_if ulpi();
	uph_phy_end i_uph_phy_end (.clk, .rst, .ulpi, .reference_clock_in(ref_clk), .vbus_in,
		.vbus_out, .vbus_oe, .speaker_switch_closed, .vbus_pulse_req, .vbus_seen, .ptx_valid,
		.ptx_data, .ptx_last, .ptx_ready, .rx_ready, .rx_data(p_rx_data),
		.rx_valid(p_rx_valid), .rx_last(p_rx_last));
	uph_link_end i_uph_link_end (.clk, .rst, .ulpi, .phy_reset_req, .tx_valid, .tx_data,
		.tx_last, .tx_ready, .rx_data(l_rx_data), .rx_valid(l_rx_valid), .rx_end(l_rx_end));
	uph_asserts i_uph_asserts (.clk, .rst, .if_clk(ulpi.if_clk), .dir(ulpi.dir),
		.interface_clock_oe(ulpi.interface_clock_oe), .phy_dir_oe(ulpi.phy_dir_oe),
		.nxt(ulpi.nxt), .phy_nxt_oe(ulpi.phy_nxt_oe), .data(ulpi.data), .stp(ulpi.stp),
		.phy_data_oe(ulpi.phy_data_oe), .link_data_oe(ulpi.link_data_oe),
		.chip_reset_low(ulpi.chip_reset_low));
	// ==========================================
	// Compare and closing tasks
	task automatic chk_bit(input string nm, input logic e, input logic g);
		n_compared++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task end_sim;
		$display("compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ==========================================
	// Monitors and hang guard
	always @(posedge clk)
	begin
		if (p_rx_valid === 1'b1)
			prx.push_back({p_rx_last, p_rx_data});
		if (l_rx_valid === 1'b1)
			lrx.push_back(l_rx_data);
		if (l_rx_end === 1'b1)
			n_end++;
		cyc++;
		// Whole run needs some 700 cycles
		if (cyc == 20000)
		begin
			n_errors++;
			$display("[FAIL] run time expected below 20000 cycles seen hang");
			end_sim();
		end
	end
	// Mid-period sample, away from every launch edge
	always @(negedge ulpi.if_clk)
		if (ulpi.nxt === 1'b1 && ulpi.stp !== 1'b1)
			wq.push_back(ulpi.data);
	// ==========================================
	// Stream driving and checking
	// Either source holds each byte until its ready is seen
	task automatic send(input logic up, input int n, input logic [7:0] b0);
		for (int i = 0; i < n; i++)
		begin
			@(negedge clk);
			if (up)
				{ptx_valid, ptx_data, ptx_last} = {1'b1, b0 + 8'(i), 1'(i == n - 1)};
			else
				{tx_valid, tx_data, tx_last} = {1'b1, b0 + 8'(i), 1'(i == n - 1)};
			do @(posedge clk); while ((up ? ptx_ready : tx_ready) !== 1'b1);
		end
		@(negedge clk);
		{ptx_valid, ptx_last, tx_valid, tx_last} = 4'h0;
	endtask
	task automatic run_row(input logic up, input int n, input logic [7:0] b0, input logic stall);
		int e0;
		logic [8:0] g;
		e0 = n_end;
		wq.delete();
		rx_ready = !stall;
		fork
			send(up, n, b0);
		join_none
		// Receiver held off: nothing may be taken meanwhile
		if (stall)
		begin
			repeat (40) @(negedge clk);
			chk_bit("stall quiet", 1'b1, 1'(wq.size() + prx.size() == 0));
			rx_ready = 1'b1;
		end
		wait fork;
		while (prx.size() + lrx.size() < n || (up && n_end == e0))
			@(posedge clk);
		for (int i = 0; i < n; i++)
		begin
			chk_byte("wire byte", b0 + 8'(i), wq[i]);
			if (up)
				chk_byte("link rx", b0 + 8'(i), lrx.pop_front());
			else
			begin
				g = prx.pop_front();
				chk_byte("phy rx", b0 + 8'(i), g[7:0]);
				chk_bit("phy last", 1'(i == n - 1), g[8]);
			end
		end
		if (up)
			chk_bit("dir release", 1'b1, 1'(n_end == e0 + 1));
		chk_bit("wire count", 1'b1, 1'(wq.size() == n));
		repeat (16) @(negedge clk);
		$display("test stream up=%0b n=%0d done", up, n);
	endtask
	task automatic sleep_chk(input logic s);
		chk_bit("clock oe", !s, ulpi.interface_clock_oe);
		chk_bit("speaker", s, speaker_switch_closed);
		chk_bit("vbus oe", !s, vbus_oe);
		if (s)
			chk_bit("pin oe", 1'b0, ulpi.phy_dir_oe | ulpi.phy_nxt_oe | ulpi.phy_data_oe);
	endtask
	// ==========================================
	// Main sequence
	initial
	begin
		repeat (3) @(negedge clk);
		sleep_chk(1'b1);
		chk_bit("reset pin", 1'b0, ulpi.chip_reset_low);
		rst = 1'b0;
		// Wait on falling edges so every later input moves off the sampling edge
		while (ulpi.if_clk !== 1'b1)
			@(negedge clk);
		chk_bit("vbus seen", 1'b0, vbus_seen);
		foreach (rows[k])
			run_row(rows[k].up, rows[k].n, rows[k].b0, 1'b0);
		run_row(1'b0, 3, 8'h5a, 1'b1);
		// Sleep by pin with a pulse request pending
		phy_reset_req = 1'b1;
		vbus_pulse_req = 1'b1;
		repeat (4) @(negedge clk);
		sleep_chk(1'b1);
		phy_reset_req = 1'b0;
		repeat (4) @(negedge clk);
		sleep_chk(1'b0);
		vbus_in = 1'b1;
		vbus_pulse_req = 1'b0;
		repeat (4) @(negedge clk);
		chk_bit("vbus seen", 1'b1, vbus_seen);
		chk_bit("vbus oe", 1'b0, vbus_oe);
		chk_bit("vbus out", 1'b1, vbus_out);
		$display("test sleep and vbus done");
		run_row(1'b1, 2, 8'h3c, 1'b0);
		// Second reset in mid-run, then normal traffic again
		rst = 1'b1;
		repeat (3) @(negedge clk);
		sleep_chk(1'b1);
		chk_bit("stop idle", 1'b0, ulpi.stp);
		rst = 1'b0;
		while (ulpi.if_clk !== 1'b1)
			@(negedge clk);
		run_row(1'b0, 2, 8'hc3, 1'b0);
		run_row(1'b1, 2, 8'h0f, 1'b0);
		end_sim();
	end
endmodule
